/* File: design/stp_top.sv */
/*
  Serial test byte transmitter: Avalon-MM registers, key guard, byte sequencer.
  Assumes an external timer overflow level and a diagnostic receiver on the pin.
*/
// The Avalon-MM register port was left to the implementer.
`timescale 1ns/1ps
module stp_top (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic [31:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  input wire logic timer_overflow,
  output logic serial_test_port_out
);

  stp_pkg::stp_main_t r;
  stp_pkg::stp_main_t next_r;

  logic tick;
  logic f_busy;
  logic f_done;
  logic f_pin;
  logic acc_wr;
  logic [2:0] cnt_code;
  logic [1:0] last_reg;
  logic [3:0] st_bits;
  logic [15:0] ctl_read;
  logic [7:0] cur_byte;
  logic [15:0] cur_word;
  logic commit;

  // ----------------------------------------------------------------
  // Leaf blocks
  // ----------------------------------------------------------------
  stp_tick_sync u_sync (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .ovf_in(timer_overflow),
    .tick(tick)
  );

  stp_frame_tx u_frame (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .tick(tick),
    .start(r.go),
    .abort(r.seq == stp_pkg::STP_SEQ_IDLE),
    .tx_byte(cur_byte),
    .busy(f_busy),
    .done(f_done),
    .pin(f_pin)
  );

  // ----------------------------------------------------------------
  // Derived values
  // ----------------------------------------------------------------
  assign cnt_code = r.ctl[stp_pkg::STP_CTL_CNT_MSB:stp_pkg::STP_CTL_CNT_LSB];
  assign last_reg = cnt_code[2:1];
  assign st_bits = (r.seq == stp_pkg::STP_SEQ_SEND) ? {1'b0, r.idx} + 4'h1 : 4'h0;
  assign ctl_read = {7'h00, st_bits, r.ctl};
  assign cur_word = r.dat[r.idx[2:1]];
  assign cur_byte = r.idx[0] ? cur_word[15:8] : cur_word[7:0];
  assign acc_wr = write && r.ack;
  assign commit = acc_wr && address == stp_pkg::STP_KEY1_ADDR
    && writedata[15:0] == stp_pkg::STP_KEY1_VAL && r.pend;

  assign waitrequest = (read || write) && !r.ack;
  assign readdata = r.rdata;
  assign serial_test_port_out = f_pin;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    logic [1:0] wreg;
    logic wdat;
    logic [2:0] need;
    wreg = 2'd0;
    wdat = 1'b0;
    need = 3'b000;
    next_r = r;
    next_r.go = 1'b0;
    next_r.ack = (read || write) && !r.ack;

    // Read mux, answered one cycle after the request
    if (read && !r.ack) begin
      unique case (address)
        stp_pkg::STP_CTL_ADDR: next_r.rdata = {16'h0000, ctl_read};
        stp_pkg::STP_DAT0_ADDR: next_r.rdata = {16'h0000, r.dat[0]};
        stp_pkg::STP_DAT1_ADDR: next_r.rdata = {16'h0000, r.dat[1]};
        stp_pkg::STP_DAT2_ADDR: next_r.rdata = {16'h0000, r.dat[2]};
        default: next_r.rdata = 32'h00000000;
      endcase
    end

    // Write side: key guard and data registers
    if (acc_wr) begin
      next_r.armed = address == stp_pkg::STP_KEY0_ADDR
        && writedata[15:0] == stp_pkg::STP_KEY0_VAL;
      next_r.pend = 1'b0;
      if (address == stp_pkg::STP_CTL_ADDR && r.armed) begin
        next_r.pend = 1'b1;
        next_r.pend_val = writedata[4:0];
      end
      unique case (address)
        stp_pkg::STP_DAT0_ADDR: begin
          wreg = 2'd0;
          wdat = 1'b1;
        end
        stp_pkg::STP_DAT1_ADDR: begin
          wreg = 2'd1;
          wdat = 1'b1;
        end
        stp_pkg::STP_DAT2_ADDR: begin
          wreg = 2'd2;
          wdat = 1'b1;
        end
        default: wdat = 1'b0;
      endcase
      if (wdat) begin
        next_r.dat[wreg] = writedata[15:0];
        next_r.wmask[wreg] = 1'b1;
      end
    end

    // Sequencer
    unique case (r.seq)
      stp_pkg::STP_SEQ_IDLE: begin
        need = (last_reg == 2'd0) ? 3'b001 : (last_reg == 2'd1) ? 3'b011 : 3'b111;
        if (wdat && wreg == last_reg && r.ctl[stp_pkg::STP_CTL_EN_BIT]
            && ((next_r.wmask & need) == need)) begin
          next_r.seq = stp_pkg::STP_SEQ_SEND;
          next_r.idx = 3'd0;
          next_r.go = 1'b1;
          next_r.wmask = 3'b000;
        end
      end
      stp_pkg::STP_SEQ_SEND: begin
        if (f_done) begin
          if (r.idx == cnt_code) begin
            next_r.seq = stp_pkg::STP_SEQ_IDLE;
            next_r.idx = 3'd0;
          end else begin
            next_r.idx = r.idx + 3'd1;
            next_r.go = 1'b1;
          end
        end
      end
      default: begin
        next_r.seq = stp_pkg::STP_SEQ_IDLE;
        next_r.idx = 3'd0;
      end
    endcase

    // Committed control write
    if (commit) begin
      if (r.pend_val[stp_pkg::STP_CTL_SRST_BIT]) begin
        next_r.ctl = stp_pkg::STP_CTL_RST;
        next_r.dat = {3{stp_pkg::STP_DAT_RST}};
        next_r.wmask = 3'b000;
        next_r.seq = stp_pkg::STP_SEQ_IDLE;
        next_r.idx = 3'd0;
        next_r.go = 1'b0;
      end else begin
        next_r.ctl = r.pend_val;
        if (!r.pend_val[stp_pkg::STP_CTL_EN_BIT]) begin
          next_r.seq = stp_pkg::STP_SEQ_IDLE;
          next_r.idx = 3'd0;
          next_r.go = 1'b0;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      r <= '{ack: 1'b0, rdata: 32'h00000000, armed: 1'b0, pend: 1'b0,
             pend_val: 5'h00, ctl: stp_pkg::STP_CTL_RST,
             dat: {3{stp_pkg::STP_DAT_RST}}, wmask: 3'b000,
             seq: stp_pkg::STP_SEQ_IDLE, idx: 3'd0, go: 1'b0};
    end else begin
      r <= next_r;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  ctl_only_commit_a: assert property (@(posedge mclk) disable iff (sys_rst)
    (r.ctl != $past(r.ctl)) |-> $past(commit))
    else $error("control changed without key sequence");

  pend_needs_key_a: assert property (@(posedge mclk) disable iff (sys_rst)
    $rose(r.pend) |-> $past(r.armed))
    else $error("control write taken without first key");

  soft_reset_a: assert property (@(posedge mclk) disable iff (sys_rst)
    (commit && r.pend_val[1]) |=> (ctl_read == 16'h0000 && r.dat[0] == 16'h0000))
    else $error("soft reset left state");

  state_bits_a: assert property (@(posedge mclk) disable iff (sys_rst)
    $fell(serial_test_port_out) |-> $past(st_bits != 4'h0))
    else $error("pin active while state bits zero");

  key_commit_a: assert property (@(posedge mclk) disable iff (sys_rst)
    (commit && !r.pend_val[stp_pkg::STP_CTL_SRST_BIT]) |=> (r.ctl == $past(r.pend_val)))
    else $error("keyed control value not applied");

  off_stays_idle_a: assert property (@(posedge mclk) disable iff (sys_rst)
    (!r.ctl[stp_pkg::STP_CTL_EN_BIT] && r.seq == stp_pkg::STP_SEQ_IDLE)
    |=> (r.seq == stp_pkg::STP_SEQ_IDLE))
    else $error("sending began while disabled");

  frame_follows_go_a: assert property (@(posedge mclk) disable iff (sys_rst)
    r.go |=> f_busy)
    else $error("frame did not start on go");

  start_on_data_a: assert property (@(posedge mclk) disable iff (sys_rst)
    $rose(r.seq == stp_pkg::STP_SEQ_SEND) |-> $past(acc_wr && r.ctl[0] && !commit))
    else $error("send began without data write");

  byte_advance_a: assert property (@(posedge mclk) disable iff (sys_rst)
    (r.seq == stp_pkg::STP_SEQ_SEND && f_done && r.idx != cnt_code && !commit)
    |=> (r.go && r.idx == $past(r.idx) + 3'd1))
    else $error("byte index did not advance");

  finish_idle_a: assert property (@(posedge mclk) disable iff (sys_rst)
    (r.seq == stp_pkg::STP_SEQ_SEND && f_done && r.idx == cnt_code)
    |=> (r.seq == stp_pkg::STP_SEQ_IDLE && ctl_read == {11'h000, r.ctl}))
    else $error("readback not restored after send");

  idle_pin_high_a: assert property (@(posedge mclk) disable iff (sys_rst)
    (r.seq == stp_pkg::STP_SEQ_IDLE && $past(r.seq == stp_pkg::STP_SEQ_IDLE))
    |-> (!f_busy && serial_test_port_out))
    else $error("pin not idle high");

endmodule : stp_top

/* File: design/stp_pkg.sv */
/*
  Constants and types for the single-pin serial test byte transmitter.
  Assumes a 32-bit Avalon-MM byte-addressed register bus on the core clock.
*/
// Contract
// - Frame: start, eight data, even parity, two stops.
// - One serial bit per bit-rate timer overflow.
// - Control write needs first key 0x0007 just before.
// - Second key 0x00B9 right after, else discarded.
// - First data register: bytes one and two.
// - Second data register: bytes three and four.
// - Third data register: bytes five and six.
// - Control bits 4..2 give byte count minus one.
// - Control bits 8..5 nonzero while sending.
// - Control bit 1 resets port; reads zero.
// - Control bit 0 enables, zero stops port.
// - No sending until all selected bytes written.
// - Busy readback differs; idle readback equals written.
package stp_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [31:0] STP_KEY0_ADDR = 32'hFFFF0880;
  localparam logic [31:0] STP_CTL_ADDR = 32'hFFFF0884;
  localparam logic [31:0] STP_KEY1_ADDR = 32'hFFFF0888;
  localparam logic [31:0] STP_DAT0_ADDR = 32'hFFFF088C;
  localparam logic [31:0] STP_DAT1_ADDR = 32'hFFFF0890;
  localparam logic [31:0] STP_DAT2_ADDR = 32'hFFFF0894;

  localparam logic [15:0] STP_KEY0_VAL = 16'h0007;
  localparam logic [15:0] STP_KEY1_VAL = 16'h00B9;
  localparam logic [15:0] STP_DAT_RST = 16'h0000;
  localparam logic [4:0] STP_CTL_RST = 5'h00;

  // ----------------------------------------------------------------
  // Control fields
  // ----------------------------------------------------------------
  localparam int STP_CTL_EN_BIT = 0;
  localparam int STP_CTL_SRST_BIT = 1;
  localparam int STP_CTL_CNT_LSB = 2;
  localparam int STP_CTL_CNT_MSB = 4;
  localparam int STP_CTL_ST_LSB = 5;
  localparam int STP_CTL_ST_MSB = 8;

  // ----------------------------------------------------------------
  // Frame
  // ----------------------------------------------------------------
  localparam logic [3:0] STP_FRAME_BITS = 4'hC;
  localparam logic [3:0] STP_PARITY_POS = 4'h9;
  localparam logic STP_IDLE_LVL = 1'b1;

  typedef enum logic [1:0] {
    STP_SEQ_IDLE = 2'b01,
    STP_SEQ_SEND = 2'b10
  } stp_seq_t;

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
  } stp_sync_t;

  typedef struct packed {
    logic busy;
    logic [3:0] cnt;
    logic [11:0] sh;
    logic pin;
    logic done;
  } stp_frame_t;

  typedef struct packed {
    logic ack;
    logic [31:0] rdata;
    logic armed;
    logic pend;
    logic [4:0] pend_val;
    logic [4:0] ctl;
    logic [2:0][15:0] dat;
    logic [2:0] wmask;
    stp_seq_t seq;
    logic [2:0] idx;
    logic go;
  } stp_main_t;

endpackage : stp_pkg

/* File: design/stp_tick_sync.sv */
/*
  Two-flop synchroniser for the bit-rate timer overflow, with rising-edge pulse.
  Assumes the overflow level may come from outside the core clock domain.
*/
`timescale 1ns/1ps
module stp_tick_sync (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic ovf_in,
  output logic tick
);

  stp_pkg::stp_sync_t r;
  stp_pkg::stp_sync_t next_r;

  // ----------------------------------------------------------------
  // Sync chain
  // ----------------------------------------------------------------
  always_comb begin
    next_r.s1 = ovf_in;
    next_r.s2 = r.s1;
    next_r.s3 = r.s2;
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign tick = r.s2 & ~r.s3;

endmodule : stp_tick_sync

/* File: design/stp_frame_tx.sv */
/*
  One 12-bit serial frame shifter, one bit per tick.
  Assumes start is a single-cycle pulse given only while not busy.
*/
`timescale 1ns/1ps
module stp_frame_tx (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic tick,
  input wire logic start,
  input wire logic abort,
  input wire logic [7:0] tx_byte,
  output logic busy,
  output logic done,
  output logic pin
);

  stp_pkg::stp_frame_t r;
  stp_pkg::stp_frame_t next_r;

  // ----------------------------------------------------------------
  // Shifter
  // ----------------------------------------------------------------
  always_comb begin
    next_r = r;
    next_r.done = 1'b0;
    if (abort) begin
      next_r.busy = 1'b0;
      next_r.pin = stp_pkg::STP_IDLE_LVL;
    end else if (start && !r.busy) begin
      next_r.busy = 1'b1;
      next_r.cnt = 4'h0;
      next_r.sh = {2'b11, ^tx_byte, tx_byte, ~stp_pkg::STP_IDLE_LVL};
    end else if (r.busy && tick) begin
      if (r.cnt == stp_pkg::STP_FRAME_BITS) begin
        next_r.busy = 1'b0;
        next_r.done = 1'b1;
        next_r.pin = stp_pkg::STP_IDLE_LVL;
      end else begin
        next_r.pin = r.sh[0];
        next_r.sh = {1'b1, r.sh[11:1]};
        next_r.cnt = r.cnt + 4'h1;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      r <= '{busy: 1'b0, cnt: 4'h0, sh: 12'hFFF, pin: 1'b1, done: 1'b0};
    end else begin
      r <= next_r;
    end
  end

  assign busy = r.busy;
  assign done = r.done;
  assign pin = r.pin;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  start_bit_low_a: assert property (@(posedge mclk) disable iff (sys_rst)
    (r.busy && tick && !abort && r.cnt == 4'h0) |=> (r.pin == 1'b0))
    else $error("start bit not low");

  stop_bits_high_a: assert property (@(posedge mclk) disable iff (sys_rst)
    (r.busy && tick && !abort && r.cnt >= 4'hA) |=> (r.pin == 1'b1))
    else $error("stop bit not high");

  pin_on_tick_a: assert property (@(posedge mclk) disable iff (sys_rst)
    $changed(r.pin) |-> $past(tick || abort))
    else $error("pin moved without tick");

endmodule : stp_frame_tx

/* File: tb/stp_rx_model.sv */
/*
  Diagnostic receiver model watching the serial test pin.
  Assumes the bit time equals the bench overflow period in mclk cycles.
*/
`timescale 1ns/1ps
module stp_rx_model #(
  parameter int BIT_CYC = 16
) (
  input wire logic mclk,
  input wire logic line,
  output logic rx_valid,
  output logic [8:0] rx_word
);
  // ----------------------------------------------------------------
  // Frame capture
  // ----------------------------------------------------------------
  logic [10:0] f;
  int i;
  initial begin
    rx_valid = 1'b0;
    rx_word = 9'h000;
    forever begin
      @(negedge line);
      repeat (BIT_CYC / 2) @(negedge mclk);
      if (line === 1'b0) begin
        for (i = 0; i < 11; i++) begin
          repeat (BIT_CYC) @(negedge mclk);
          f[i] = line;
        end
        // Error flag on odd parity or a low stop bit
        rx_word = {(^f[8:0]) | ~f[9] | ~f[10], f[7:0]};
        rx_valid = 1'b1;
        @(negedge mclk);
        rx_valid = 1'b0;
      end
    end
  end
endmodule : stp_rx_model

/* File: tb/serial_test_byte_transmitter_tb.sv */
/*
  Self-checking bench for the serial test byte transmitter.
  Assumes the receiver model on the pin and an overflow every 16 cycles.
*/
`timescale 1ns/1ps
module serial_test_byte_transmitter_tb;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic mclk, sys_rst, read, write, waitrequest, timer_overflow, pin, rx_valid;
  logic [31:0] address, writedata, readdata;
  logic [8:0] rx_word;
  logic [8:0] rxq[$];
  logic [3:0] tcnt;
  int failures, num_checks, c;

  stp_top dut_u (.mclk(mclk), .sys_rst(sys_rst), .address(address), .read(read),
    .write(write), .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
    .timer_overflow(timer_overflow), .serial_test_port_out(pin));
  stp_rx_model #(.BIT_CYC(16)) rx_u (.mclk(mclk), .line(pin), .rx_valid(rx_valid),
    .rx_word(rx_word));

  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  // Overflow pulse every 16 cycles
  always @(posedge mclk) begin
    tcnt <= tcnt + 4'h1;
    timer_overflow <= (tcnt == 4'hF);
  end
  always @(posedge mclk) if (rx_valid === 1'b1) rxq.push_back(rx_word);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task summarize;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : summarize
  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic bus(input logic wr, input logic [31:0] a, input logic [15:0] d,
                     output logic [31:0] q);
    int n;
    address <= a;
    write <= wr;
    read <= ~wr;
    writedata <= {16'h0000, d};
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (waitrequest !== 1'b0 && n < 50);
    q = readdata;
    write <= 1'b0;
    read <= 1'b0;
    if (waitrequest !== 1'b0) begin
      failures++;
      summarize();
    end
    @(posedge mclk);
  endtask : bus
  task automatic wr(input logic [31:0] a, input logic [15:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask : wr
  task automatic rdc(input string what, input logic [31:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 16'h0000, q);
    chk(what, exp, q);
  endtask : rdc
  task ctl_wr(input logic [15:0] d);
    wr(stp_pkg::STP_KEY0_ADDR, stp_pkg::STP_KEY0_VAL);
    wr(stp_pkg::STP_CTL_ADDR, d);
    wr(stp_pkg::STP_KEY1_ADDR, stp_pkg::STP_KEY1_VAL);
  endtask : ctl_wr
  task automatic idle_chk(input int cyc);
    int lows;
    lows = 0;
    repeat (cyc) begin
      @(negedge mclk);
      if (pin !== 1'b1) lows++;
    end
    chk("pin idle", 0, lows);
    @(posedge mclk);
  endtask : idle_chk

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset;
    int k;
    for (k = 0; k < 7; k++) rdc("reset value", stp_pkg::STP_KEY0_ADDR + 4 * k, 0);
    chk("pin after reset", 1, pin);
  endtask : t_reset
  task t_keys;
    wr(stp_pkg::STP_CTL_ADDR, 16'h0001);
    rdc("no key", stp_pkg::STP_CTL_ADDR, 0);
    wr(stp_pkg::STP_KEY0_ADDR, 16'h0006);
    wr(stp_pkg::STP_CTL_ADDR, 16'h0001);
    wr(stp_pkg::STP_KEY1_ADDR, 16'h00B9);
    rdc("bad first key", stp_pkg::STP_CTL_ADDR, 0);
    wr(stp_pkg::STP_KEY0_ADDR, 16'h0007);
    wr(stp_pkg::STP_CTL_ADDR, 16'h0001);
    wr(stp_pkg::STP_KEY1_ADDR, 16'h00B8);
    rdc("bad second key", stp_pkg::STP_CTL_ADDR, 0);
    wr(stp_pkg::STP_KEY0_ADDR, 16'h0007);
    wr(stp_pkg::STP_CTL_ADDR, 16'h0001);
    wr(stp_pkg::STP_KEY0_ADDR, 16'h0007);
    wr(stp_pkg::STP_KEY1_ADDR, 16'h00B9);
    rdc("key order", stp_pkg::STP_CTL_ADDR, 0);
    ctl_wr(16'h0001);
    rdc("keyed write", stp_pkg::STP_CTL_ADDR, 1);
  endtask : t_keys
  task automatic t_send(input logic [2:0] cnt);
    logic [15:0] d[3];
    logic [15:0] cv;
    logic [31:0] q;
    int k, n;
    cv = {11'h000, cnt, 2'b01};
    ctl_wr(cv);
    rxq.delete();
    for (k = 0; k <= cnt / 2; k++) d[k] = 16'(16'h3C96 * (k + cnt + 1));
    for (k = 0; k < cnt / 2; k++) wr(stp_pkg::STP_DAT0_ADDR + 4 * k, d[k]);
    idle_chk(48);
    wr(stp_pkg::STP_DAT0_ADDR + 4 * (cnt / 2), d[cnt / 2]);
    bus(1'b0, stp_pkg::STP_CTL_ADDR, 16'h0000, q);
    chk("state busy", 1, q[8:5] !== 4'h0);
    n = 0;
    do begin
      bus(1'b0, stp_pkg::STP_CTL_ADDR, 16'h0000, q);
      n++;
    end while (q !== {16'h0000, cv} && n < 1000);
    chk("control readback", {16'h0000, cv}, q);
    if (q !== {16'h0000, cv}) summarize();
    repeat (32) @(posedge mclk);
    chk("byte count", 32'(cnt) + 1, rxq.size());
    for (k = 0; k <= cnt && k < rxq.size(); k++)
      chk("byte", {1'b0, d[k / 2][8 * (k % 2) +: 8]}, rxq[k]);
  endtask : t_send
  task t_abort;
    ctl_wr(16'h0015);
    wr(stp_pkg::STP_DAT0_ADDR, 16'h0F0F);
    wr(stp_pkg::STP_DAT1_ADDR, 16'h0F0F);
    wr(stp_pkg::STP_DAT2_ADDR, 16'h0F0F);
    repeat (40) @(posedge mclk);
    ctl_wr(16'h0002);
    rdc("soft reset control", stp_pkg::STP_CTL_ADDR, 0);
    rdc("soft reset data", stp_pkg::STP_DAT0_ADDR, 0);
    idle_chk(220);
    ctl_wr(16'h0001);
    wr(stp_pkg::STP_DAT0_ADDR, 16'h00A5);
    repeat (40) @(posedge mclk);
    ctl_wr(16'h0000);
    idle_chk(220);
    wr(stp_pkg::STP_DAT0_ADDR, 16'h00A5);
    idle_chk(220);
    rdc("disabled control", stp_pkg::STP_CTL_ADDR, 0);
  endtask : t_abort

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    failures = 0;
    num_checks = 0;
    tcnt = 4'h0;
    timer_overflow = 1'b0;
    sys_rst = 1'b1;
    read = 1'b0;
    write = 1'b0;
    address = 32'h00000000;
    writedata = 32'h00000000;
    repeat (4) @(posedge mclk);
    sys_rst <= 1'b0;
    @(posedge mclk);
    t_reset();
    t_keys();
    for (c = 0; c < 6; c++) t_send(3'(c));
    t_abort();
    summarize();
  end
endmodule : serial_test_byte_transmitter_tb
